// [inc/arb_prio_map.svh]
// register offsets, field positions and reset values of the arbiter
// priority selector; assumes inclusion by bare name from design files
`ifndef ARB_PRIO_MAP_SVH
`define ARB_PRIO_MAP_SVH
// register indices; byte address is four times the index
`define ARB_CTRL_IDX 8'h42
`define ARB_EXT_IDX 8'h43
// reset values
`define ARB_CTRL_RST 8'h04
`define ARB_EXT_RST 8'h00
// control register fields
`define ARB_ROT0_BIT 4
`define ARB_ROT1_BIT 5
`define ARB_ROT2_BIT 6
`define ARB_ROT3_BIT 7
`define ARB_FIX0_BIT 0
`define ARB_FIX1_BIT 1
`define ARB_FIX2A_BIT 2
`define ARB_FIX2B_BIT 3
// extension register field and writable mask
`define ARB_FIX3_BIT 0
`define ARB_EXT_MASK 8'h01
// group orders of bank 2
`define ARB_ORD_G0_G2_G1 2'h0
`define ARB_ORD_G1_G0_G2 2'h1
`define ARB_ORD_G2_G1_G0 2'h2
`define ARB_ORD_RSVD 2'h3
// requester index meaning no winner
`define ARB_NONE 3'h7
`endif

// [inc/arb_prio_pkg.sv]
// types shared by the arbiter priority selector
// assumes arb_prio_map.svh is on the include path
package arb_prio_pkg;
	// grant machine, gray along idle -> busy -> idle
	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_BUSY = 1'b1
	} arb_state_e;
	typedef logic [5:0] req_vec_t;
	typedef logic [1:0] order_t;
	typedef logic [2:0] req_idx_t;
endpackage : arb_prio_pkg

// [src/arb_prio_select.sv]
// six-requester bus arbiter priority selector with wishbone registers
// assumes one clock, synchronous inputs, classic wishbone master
`timescale 1ns/1ps
`default_nettype none
`include "arb_prio_map.svh"

module arb_prio_select
	import arb_prio_pkg::*;
#(
	parameter int ADR_W = 10
) (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// requests, active high
	input wire logic bridge_own_request_i,
	input wire logic master0_request_i,
	input wire logic host_cpu_request_i,
	input wire logic master1_request_i,
	input wire logic master2_request_i,
	input wire logic master3_request_i,
	// grants, one-hot
	output logic bridge_own_grant_o,
	output logic master0_grant_o,
	output logic host_cpu_grant_o,
	output logic master1_grant_o,
	output logic master2_grant_o,
	output logic master3_grant_o
);
	import arb_prio_pkg::*;

	// refuse a bus too narrow for the register indices
	if (ADR_W < 10) begin : g_adr_chk
		$error("ADR_W must be at least 10");
	end

	// decoded word index of a byte address
	function automatic logic [7:0] word_idx(input logic [ADR_W-1:0] a);
		word_idx = a[9:2];
	endfunction : word_idx

	// group occupying a position in a bank 2 order
	function automatic logic [1:0] grp_at(input order_t o,
		input logic [1:0] pos);
		logic [5:0] tbl;
		tbl = 6'h00;
		case (o)
			`ARB_ORD_G1_G0_G2: tbl = {2'd2, 2'd0, 2'd1};
			`ARB_ORD_G2_G1_G0: tbl = {2'd0, 2'd1, 2'd2};
			default: tbl = {2'd1, 2'd2, 2'd0};
		endcase
		case (pos)
			2'd0: grp_at = tbl[1:0];
			2'd1: grp_at = tbl[3:2];
			default: grp_at = tbl[5:4];
		endcase
	endfunction : grp_at

	// registers
	logic [7:0] ctrl_q, ctrl_d;
	logic [7:0] ext_q, ext_d;
	logic ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	arb_state_e st_q, st_d;
	req_vec_t grant_q, grant_d;
	logic [2:0] tgl_q, tgl_d;
	order_t ord_q, ord_d;

	req_vec_t req;
	logic [2:0] gsel;
	logic [2:0] grot;
	order_t ord_eff;
	req_idx_t gwin [3];
	req_idx_t win;
	logic bus_req;
	logic bus_wr;
	logic [7:0] adr_idx;

	assign req = {master3_request_i, master2_request_i,
		master1_request_i, host_cpu_request_i,
		master0_request_i, bridge_own_request_i};
	assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
	// a write lands at the edge where the master sees ack high
	assign bus_wr = wb_cyc_i & wb_stb_i & ack_q & wb_we_i & wb_sel_i[0];
	assign adr_idx = word_idx(wb_adr_i);

	// register access: one ack a cycle after the request
	always_comb begin
		ctrl_d = ctrl_q;
		ext_d = ext_q;
		ack_d = bus_req;
		rdat_d = 32'h0000_0000;
		if (bus_req && adr_idx == `ARB_CTRL_IDX) begin
			rdat_d[7:0] = ctrl_q;
		end
		if (bus_req && adr_idx == `ARB_EXT_IDX) begin
			rdat_d[7:0] = ext_q & `ARB_EXT_MASK;
		end
		if (bus_wr && adr_idx == `ARB_CTRL_IDX) begin
			ctrl_d = wb_dat_i[7:0];
		end
		if (bus_wr && adr_idx == `ARB_EXT_IDX) begin
			ext_d = wb_dat_i[7:0] & `ARB_EXT_MASK;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			ctrl_q <= `ARB_CTRL_RST;
			ext_q <= `ARB_EXT_RST;
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ctrl_q <= ctrl_d;
			ext_q <= ext_d;
			ack_q <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// per-pair rotate enables and fixed selects
	assign grot = {ctrl_q[`ARB_ROT3_BIT], ctrl_q[`ARB_ROT1_BIT],
		ctrl_q[`ARB_ROT0_BIT]};
	// rotation overrides fixed order in each pair
	assign gsel[0] = grot[0] ? tgl_q[0] :
		ctrl_q[`ARB_FIX0_BIT];
	assign gsel[1] = grot[1] ? tgl_q[1] :
		ctrl_q[`ARB_FIX1_BIT];
	assign gsel[2] = grot[2] ? tgl_q[2] :
		ext_q[`ARB_FIX3_BIT];
	// bank 2 group order; reserved code falls back to order 00
	assign ord_eff = ctrl_q[`ARB_ROT2_BIT] ? ord_q :
		{ctrl_q[`ARB_FIX2B_BIT], ctrl_q[`ARB_FIX2A_BIT]};

	// winner of each pair: higher input, else lower
	for (genvar k = 0; k < 3; k++) begin : g_pair
		always_comb begin
			logic hi;
			logic lo;
			hi = gsel[k];
			lo = ~gsel[k];
			gwin[k] = `ARB_NONE;
			if (req[2*k+hi]) begin
				gwin[k] = 3'(2*k) + {2'b00, hi};
			end else if (req[2*k+lo]) begin
				gwin[k] = 3'(2*k) + {2'b00, lo};
			end
		end
	end

	// winner across groups in bank 2 order
	always_comb begin
		win = `ARB_NONE;
		for (int p = 2; p >= 0; p--) begin
			if (gwin[grp_at(ord_eff, 2'(p))] != `ARB_NONE) begin
				win = gwin[grp_at(ord_eff, 2'(p))];
			end
		end
	end

	// grant machine and rotation state
	always_comb begin
		st_d = st_q;
		grant_d = grant_q;
		tgl_d = tgl_q;
		ord_d = ord_q;
		case (st_q)
			ST_IDLE: begin
				if (win != `ARB_NONE) begin
					grant_d = req_vec_t'(6'h01 << win);
					st_d = ST_BUSY;
					// toggle a pair only when its higher input is served;
					// a lower input served alone leaves the rotation
					for (int k = 0; k < 3; k++) begin
						if (grot[k] && win[2:1] == 2'(k) &&
							win[0] == gsel[k]) begin
							tgl_d[k] = ~tgl_q[k];
						end
					end
					// bank 2 moves lowest group to the top
					if (ctrl_q[`ARB_ROT2_BIT]) begin
						case (ord_q)
							`ARB_ORD_G0_G2_G1: ord_d = `ARB_ORD_G1_G0_G2;
							`ARB_ORD_G1_G0_G2: ord_d = `ARB_ORD_G2_G1_G0;
							default: ord_d = `ARB_ORD_G0_G2_G1;
						endcase
					end
				end
			end
			ST_BUSY: begin
				// hold the grant while its owner still requests
				if ((req & grant_q) == 6'h00) begin
					grant_d = 6'h00;
					st_d = ST_IDLE;
				end
			end
			default: begin
				grant_d = 6'h00;
				st_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (reset_i) begin
			st_q <= ST_IDLE;
			grant_q <= 6'h00;
			tgl_q <= 3'h0;
			ord_q <= `ARB_ORD_G0_G2_G1;
		end else begin
			st_q <= st_d;
			grant_q <= grant_d;
			tgl_q <= tgl_d;
			ord_q <= ord_d;
		end
	end

	// grant outputs straight from the grant register
	assign bridge_own_grant_o = grant_q[0];
	assign master0_grant_o = grant_q[1];
	assign host_cpu_grant_o = grant_q[2];
	assign master1_grant_o = grant_q[3];
	assign master2_grant_o = grant_q[4];
	assign master3_grant_o = grant_q[5];

	// checks on grants, rotation and register answers
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	logic new_gnt;
	assign new_gnt = st_q == ST_IDLE && win != `ARB_NONE;

	a_grant_onehot: assert property ($onehot0(grant_q))
		else $error("more than one grant");
	a_grant_held: assert property (st_q == ST_BUSY &&
		(req & grant_q) != 6'h00 |=> $stable(grant_q))
		else $error("grant disturbed while owner requests");
	a_idle_grants: assert property (new_gnt |=>
		grant_q != 6'h00 && st_q == ST_BUSY)
		else $error("request left unserved");
	a_rotate_wins: assert property (new_gnt && grot[0] &&
		ctrl_q[`ARB_FIX0_BIT] && !tgl_q[0] && req[0] |=>
		grant_q[0] || (grant_q[3:2] | grant_q[5:4]) != 2'h0)
		else $error("fixed select beat rotate");
	a_bank0_order: assert property (new_gnt && !grot[0] &&
		!ctrl_q[`ARB_FIX0_BIT] && req[0] && win[2:1] == 2'h0
		|=> grant_q[0])
		else $error("bridge lost to master 0");
	a_bank3_order: assert property (new_gnt && !grot[2] &&
		ext_q[0] && req[5] && win[2:1] == 2'h2
		|=> grant_q[5])
		else $error("master 3 not preferred");
	a_toggle_flip: assert property (new_gnt && grot[1] &&
		win[2:1] == 2'h1 && win[0] == gsel[1]
		|=> tgl_q[1] != $past(tgl_q[1]))
		else $error("bank 1 failed to toggle");
	a_low_keeps: assert property (new_gnt && grot[0] &&
		win[2:1] == 2'h0 && win[0] != gsel[0]
		|=> $stable(tgl_q[0]))
		else $error("lower grant moved bank 0 rotation");
	a_no_toggle: assert property (!new_gnt |=>
		$stable(tgl_q) && $stable(ord_q))
		else $error("rotation moved without grant");
	a_ord_step: assert property (new_gnt &&
		ctrl_q[`ARB_ROT2_BIT] && ord_q == `ARB_ORD_G0_G2_G1
		|=> ord_q == `ARB_ORD_G1_G0_G2)
		else $error("bank 2 rotation misstep");
	a_ext_zero: assert property (ack_q |->
		rdat_q[31:1] == 31'h0 || $past(adr_idx) != `ARB_EXT_IDX)
		else $error("extension reserved bits not zero");
	a_ack_pulse: assert property (ack_q |=> !ack_q)
		else $error("ack longer than one cycle");

	c_rot_grant: cover property (new_gnt && grot != 3'h0);
	c_busy_hold: cover property (st_q == ST_BUSY [*3]);
	c_ctrl_write: cover property (ack_q && $past(wb_we_i));
	c_ord_wrap: cover property (ord_q == `ARB_ORD_G2_G1_G0 ##1
		ord_q == `ARB_ORD_G0_G2_G1);
endmodule : arb_prio_select
`default_nettype wire

// [tb/pci_arbiter_priority_select_test.sv]
// bench for the arbiter priority selector: registers, fixed and rotating
// orders; assumes req_masters as the requesting masters
`timescale 1ns/1ps
`default_nettype none
module pci_arbiter_priority_select_test;
	logic core_clk_i, reset_i, cyc, stb, we, ack;
	logic [9:0] adr;
	logic [31:0] wdat, rdat;
	logic [5:0] want, req;
	wire logic [5:0] gnt;
	int err_count, tests_run;
	// clock
	initial begin
		core_clk_i = 1'b0;
		forever #12.5 core_clk_i = ~core_clk_i;
	end
	arb_prio_select arb_prio_select_i (.core_clk_i(core_clk_i),
		.reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .bridge_own_request_i(req[0]),
		.master0_request_i(req[1]), .host_cpu_request_i(req[2]),
		.master1_request_i(req[3]), .master2_request_i(req[4]),
		.master3_request_i(req[5]), .bridge_own_grant_o(gnt[0]),
		.master0_grant_o(gnt[1]), .host_cpu_grant_o(gnt[2]),
		.master1_grant_o(gnt[3]), .master2_grant_o(gnt[4]),
		.master3_grant_o(gnt[5]));
	req_masters req_masters_i (.core_clk_i(core_clk_i), .reset_i(reset_i),
		.want_i(want), .grant_i(gnt), .req_o(req));
	task results;
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results
	task check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	task hang;
		err_count++;
		$display("ERROR %0t wait ran out", $time);
		results();
	endtask : hang
	task do_reset;
		reset_i <= 1'b1;
		want <= 6'h00;
		repeat (12) @(posedge core_clk_i);
		reset_i <= 1'b0;
		@(posedge core_clk_i);
	endtask : do_reset
	// one classic wishbone cycle, data taken at the ack edge
	task wb(input logic w, input logic [9:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		n = 0;
		@(posedge core_clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h000000, d};
		do begin
			@(posedge core_clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1)
			hang();
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	// next grant after an idle cycle, as requester index
	task get_gnt(output logic [3:0] w);
		int n;
		n = 0;
		while (gnt !== 6'h00 && n < 40) begin
			@(posedge core_clk_i);
			n++;
		end
		while (gnt === 6'h00 && n < 40) begin
			@(posedge core_clk_i);
			n++;
		end
		if (n >= 40)
			hang();
		w = 4'hF;
		for (int i = 0; i < 6; i++)
			if (gnt[i] === 1'b1)
				w = 4'(i);
	endtask : get_gnt
	// latch a one-cycle wish once no grant is held
	task pulse(input logic [5:0] m);
		int n;
		n = 0;
		while (gnt !== 6'h00 && n < 40) begin
			@(posedge core_clk_i);
			n++;
		end
		if (n >= 40)
			hang();
		@(posedge core_clk_i);
		want <= m;
		@(posedge core_clk_i);
		want <= 6'h00;
	endtask : pulse
	// the next grant must go to requester e
	task grant_is(input logic [3:0] e);
		logic [3:0] w;
		get_gnt(w);
		check({4'h0, w}, {4'h0, e});
	endtask : grant_is
	task t_regs;
		logic [7:0] q;
		do_reset();
		wb(1'b0, 10'h108, 8'h00, q);
		check(q, 8'h04);
		wb(1'b1, 10'h10C, 8'hFF, q);
		wb(1'b0, 10'h10C, 8'h00, q);
		check(q, 8'h01);
		wb(1'b0, 10'h110, 8'h00, q);
		check(q, 8'h00);
	endtask : t_regs
	// all six request at once; grants follow the fixed order
	task t_order(input logic [7:0] c, input logic [7:0] x,
		input logic [23:0] ord);
		logic [7:0] q;
		logic [3:0] w;
		do_reset();
		wb(1'b1, 10'h108, c, q);
		wb(1'b1, 10'h10C, x, q);
		pulse(6'h3F);
		for (int i = 5; i >= 0; i--) begin
			get_gnt(w);
			check({4'h0, w}, {4'h0, ord[i*4+:4]});
		end
	endtask : t_order
	// bank 0 rotates although its fixed bit is set, then fixed alone
	task t_rot;
		logic [7:0] q;
		do_reset();
		wb(1'b1, 10'h108, 8'h11, q);
		pulse(6'h03);
		grant_is(4'h0);
		grant_is(4'h1);
		// master 0 alone is the lower input: rotation must stay
		pulse(6'h02);
		grant_is(4'h1);
		pulse(6'h03);
		grant_is(4'h0);
		grant_is(4'h1);
		pulse(6'h01);
		grant_is(4'h0);
		pulse(6'h03);
		grant_is(4'h1);
		grant_is(4'h0);
		do_reset();
		wb(1'b1, 10'h108, 8'h01, q);
		for (int i = 0; i < 2; i++) begin
			pulse(6'h03);
			grant_is(4'h1);
			grant_is(4'h0);
		end
	endtask : t_rot
	// every bank rotating; all six served within two rotations
	task t_fair;
		logic [7:0] q;
		logic [3:0] w;
		logic [5:0] seen;
		do_reset();
		seen = 6'h00;
		wb(1'b1, 10'h108, 8'hF0, q);
		want <= 6'h3F;
		for (int i = 0; i < 12; i++) begin
			get_gnt(w);
			seen[w[2:0]] = 1'b1;
		end
		check({2'h0, seen}, 8'h3F);
	endtask : t_fair
	// main sequence
	initial begin
		err_count = 0;
		tests_run = 0;
		reset_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 10'h000;
		wdat = 32'h00000000;
		want = 6'h00;
		t_regs();
		t_order(8'h04, 8'h00, 24'h230145);
		t_order(8'h00, 8'h00, 24'h014523);
		t_order(8'h06, 8'h00, 24'h320145);
		t_order(8'h09, 8'h00, 24'h452310);
		t_order(8'h05, 8'h01, 24'h231054);
		t_order(8'h0B, 8'h01, 24'h543210);
		t_rot();
		t_fair();
		results();
	end
endmodule : pci_arbiter_priority_select_test
`default_nettype wire

// [tb/req_masters.sv]
// bus masters beside the arbiter: raise a request, drop it after use
// assumes one-hot active-high grants sampled on the rising edge
`timescale 1ns/1ps
`default_nettype none
module req_masters (
	// clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// wishes and grants
	input wire logic [5:0] want_i,
	input wire logic [5:0] grant_i,
	// requests
	output logic [5:0] req_o
);
	logic [5:0] req_q, req_d, used_q, used_d;
	// keep a request until granted two cycles; a held wish re-requests
	always_comb begin
		used_d = grant_i & req_q;
		req_d = (req_q | want_i) & ~(used_q & grant_i);
	end
	// state registers
	always_ff @(posedge core_clk_i) begin
		req_q <= reset_i ? 6'h00 : req_d;
		used_q <= reset_i ? 6'h00 : used_d;
	end
	assign req_o = req_q;
endmodule : req_masters
`default_nettype wire
